// ==== rtl/pfo_pkg.sv ====
// Package for the PWM fault override block: register map, fields, resets
package pfo_pkg;
  localparam int unsigned ADDR_W = 4;
  // Byte offsets of the Avalon word registers
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_MASK = 4'h8;
  localparam logic [3:0] OFF_DATA = 4'hC;
  // Control register fields
  localparam int unsigned SRC_LSB = 3;
  localparam int unsigned SRC_MSB = 7;
  localparam int unsigned POL_BIT = 2;
  localparam int unsigned MOD_LSB = 0;
  localparam int unsigned MOD_MSB = 1;
  localparam logic [15:0] CTRL_RST = 16'h00F8;
  localparam logic [4:0] SRC_RESERVED = 5'h1E;
  // Fault modes
  localparam logic [1:0] MODE_LATCH = 2'h0;
  localparam logic [1:0] MODE_CYCLE = 2'h1;
  localparam logic [1:0] MODE_RSVD = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  // Status and mask bits
  localparam int unsigned ST_FAULT = 0;
  localparam int unsigned ST_RELEASE = 1;
  localparam int unsigned ST_W = 2;
  // Override data register: bit 0 high output, bit 1 low output
  localparam int unsigned OVR_HI = 0;
  localparam int unsigned OVR_LO = 1;
  // Latch clear command is bit 0 of a write to the status offset's second byte
  localparam int unsigned LATCH_CLR_BIT = 8;
endpackage : pfo_pkg

// ==== rtl/pfo_fault_override.sv ====
// PWM generator fault select, polarity and override with Avalon-MM registers
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module pfo_fault_override (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [31:0] fault_i,
  input wire logic pwm_high_i,
  input wire logic pwm_low_i,
  input wire logic pwm_cycle_start_i,
  input wire logic pwm_timebase_enable_i,
  input wire logic [pfo_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic pwm_high_output_o,
  output logic pwm_low_output_o,
  output logic fault_override_active_o,
  output logic irq_o
);

  typedef struct packed {
    logic [31:0] flt_s1;
    logic [31:0] flt_s2;
    logic [15:0] ctrl;
    logic [1:0] fault_override_data;
    logic [pfo_pkg::ST_W-1:0] status;
    logic [pfo_pkg::ST_W-1:0] mask;
    logic active_d;
    logic override;
    logic ack;
    logic [31:0] rdata;
    logic hi;
    logic lo;
    logic irq;
  } pfo_state_t;

  logic rst_s1_reg;
  logic rst_n_reg;
  pfo_state_t st_reg;
  pfo_state_t st_next;

  // ---------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  logic [4:0] fault_source_select;
  logic fault_polarity;
  logic [1:0] fault_mode;
  logic raw;
  logic fault_active;
  logic fault_rise;
  logic hit_ctrl;
  logic hit_status;
  logic hit_mask;
  logic hit_data;
  logic [pfo_pkg::ST_W-1:0] ev;
  logic [pfo_pkg::ST_W-1:0] w1c;
  logic latch_clr;

  assign fault_source_select = st_reg.ctrl[pfo_pkg::SRC_MSB:pfo_pkg::SRC_LSB];
  assign fault_polarity = st_reg.ctrl[pfo_pkg::POL_BIT];
  assign fault_mode = st_reg.ctrl[pfo_pkg::MOD_MSB:pfo_pkg::MOD_LSB];
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_reg.ack;
  assign avs_readdata_o = st_reg.rdata;
  assign pwm_high_output_o = st_reg.hi;
  assign pwm_low_output_o = st_reg.lo;
  assign fault_override_active_o = st_reg.override;
  assign irq_o = st_reg.irq;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // -------------------------------------------------------------------
    // Fault select and polarity
    // -------------------------------------------------------------------
    st_next.flt_s1 = fault_i;
    st_next.flt_s2 = st_reg.flt_s1;
    // Reserved code picks no input, so the fault never fires from it
    if (fault_source_select == pfo_pkg::SRC_RESERVED) begin
      raw = 1'b0;
    end else begin
      raw = st_reg.flt_s2[fault_source_select] ^ fault_polarity;
    end
    // Reserved mode treated like disabled: safest undefined choice
    fault_active = raw & (fault_mode != pfo_pkg::MODE_OFF)
      & (fault_mode != pfo_pkg::MODE_RSVD);
    fault_rise = fault_active & ~st_reg.active_d;
    st_next.active_d = fault_active;

    // -------------------------------------------------------------------
    // Address decode
    // -------------------------------------------------------------------
    hit_ctrl = 1'b0;
    hit_status = 1'b0;
    hit_mask = 1'b0;
    hit_data = 1'b0;
    if (avs_address_i == pfo_pkg::OFF_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (avs_address_i == pfo_pkg::OFF_STATUS) begin
      hit_status = 1'b1;
    end else if (avs_address_i == pfo_pkg::OFF_MASK) begin
      hit_mask = 1'b1;
    end else if (avs_address_i == pfo_pkg::OFF_DATA) begin
      hit_data = 1'b1;
    end

    // -------------------------------------------------------------------
    // Bus answer and register writes
    // -------------------------------------------------------------------
    // One wait state: waitrequest drops in the cycle after the request
    st_next.ack = (avs_read_i | avs_write_i) & ~st_reg.ack;
    w1c = '0;
    latch_clr = 1'b0;
    // Write lands on the edge where waitrequest is seen low, not earlier
    if (avs_write_i && st_reg.ack) begin
      if (hit_ctrl) begin
        if (avs_byteenable_i[0]) st_next.ctrl[7:0] = avs_writedata_i[7:0];
        if (avs_byteenable_i[1]) st_next.ctrl[15:8] = avs_writedata_i[15:8];
      end else if (hit_status && avs_byteenable_i[0]) begin
        w1c = avs_writedata_i[pfo_pkg::ST_W-1:0];
      end else if (hit_mask && avs_byteenable_i[0]) begin
        st_next.mask = avs_writedata_i[pfo_pkg::ST_W-1:0];
      end else if (hit_data && avs_byteenable_i[0]) begin
        st_next.fault_override_data = avs_writedata_i[1:0];
      end
      if (hit_status && avs_byteenable_i[1]) begin
        latch_clr = avs_writedata_i[pfo_pkg::LATCH_CLR_BIT];
      end
    end
    // -------------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------------
    // Registered one edge early so it stands when waitrequest is low
    st_next.rdata = '0;
    if (avs_read_i && st_next.ack) begin
      if (hit_ctrl) begin
        st_next.rdata = {16'h0000, st_reg.ctrl};
      end else if (hit_status) begin
        st_next.rdata = {30'h0, st_reg.status};
        st_next.rdata[pfo_pkg::LATCH_CLR_BIT] = st_reg.override;
      end else if (hit_mask) begin
        st_next.rdata = {30'h0, st_reg.mask};
      end else if (hit_data) begin
        st_next.rdata = {30'h0, st_reg.fault_override_data};
      end
    end

    // -------------------------------------------------------------------
    // Override control
    // -------------------------------------------------------------------
    ev = '0;
    if (fault_active && !st_reg.override) begin
      st_next.override = 1'b1;
      ev[pfo_pkg::ST_FAULT] = 1'b1;
    end else if (st_reg.override && !fault_active) begin
      if (fault_mode == pfo_pkg::MODE_LATCH) begin
        if (latch_clr) begin
          st_next.override = 1'b0;
          ev[pfo_pkg::ST_RELEASE] = 1'b1;
        end
      end else if (pwm_cycle_start_i) begin
        st_next.override = 1'b0;
        ev[pfo_pkg::ST_RELEASE] = 1'b1;
      end
    end
    // Cycle mode reasserts instantly with no edge wait; latched edge is noted
    if (fault_rise) ev[pfo_pkg::ST_FAULT] = 1'b1;

    // -------------------------------------------------------------------
    // Status and interrupt
    // -------------------------------------------------------------------
    // Set wins over write-one-to-clear
    st_next.status = (st_reg.status & ~w1c) | ev;
    st_next.irq = |(st_next.status & st_next.mask);

    // -------------------------------------------------------------------
    // Output drive
    // -------------------------------------------------------------------
    // Outputs switch on the same edge as the override, saving a cycle
    if (st_next.override) begin
      st_next.hi = st_next.fault_override_data[pfo_pkg::OVR_HI];
      st_next.lo = st_next.fault_override_data[pfo_pkg::OVR_LO];
    end else begin
      st_next.hi = pwm_high_i;
      st_next.lo = pwm_low_i;
    end
  end

  // Time base enable is only advisory here: polarity writes are not blocked
  logic unused_tb;
  assign unused_tb = pwm_timebase_enable_i;

  // ---------------------------------------------------------------------
  // Register update
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      st_reg <= '0;
      st_reg.ctrl <= pfo_pkg::CTRL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : pfo_fault_override

// ==== dv/pfo_partner.sv ====
// Fault sources and PWM generator model on the block's far side
`timescale 1ns/1ps
module pfo_partner (
  input wire logic core_clk_i,
  input wire logic run_i,
  input wire logic [31:0] fault_set_i,
  output logic [31:0] fault_o,
  output logic pwm_high_o,
  output logic pwm_low_o,
  output logic cycle_start_o
);
  logic [2:0] cnt_reg;
  always_ff @(posedge core_clk_i) begin
    cnt_reg <= run_i ? cnt_reg + 3'h1 : 3'h0;
  end
  // Generator stands idle and low while the time base is stopped
  assign fault_o = fault_set_i;
  assign cycle_start_o = run_i && cnt_reg == 3'h0;
  assign pwm_high_o = run_i && !cnt_reg[2];
  assign pwm_low_o = run_i && cnt_reg[2];
endmodule : pfo_partner

// ==== dv/pfo_fault_override_checker.sv ====
// Port assertions and covers for the PWM fault override block
`timescale 1ns/1ps
module pfo_fault_override_checker (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic pwm_high_i,
  input wire logic pwm_low_i,
  input wire logic pwm_cycle_start_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic pwm_high_output_o,
  input wire logic pwm_low_output_o,
  input wire logic fault_override_active_o,
  input wire logic irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire req = avs_read_i || avs_write_i;
  wire act = fault_override_active_o;
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("request not held off");
  a_ack_next: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("answer late");
  a_idle_ready: assert property (!req |-> !avs_waitrequest_o)
    else $error("wait while idle");
  a_rdata_quiet: assert property ($rose(avs_read_i) |-> avs_readdata_o == 0)
    else $error("read data not zero");
  a_pass_thru: assert property (
    !act |-> pwm_high_output_o == $past(pwm_high_i)
    && pwm_low_output_o == $past(pwm_low_i)) else $error("no pass");
  a_ovr_hold: assert property (
    act && !avs_write_i ##1 act |-> $stable(pwm_high_output_o)
    && $stable(pwm_low_output_o)) else $error("override moved");
  a_release_cause: assert property (
    $fell(act) |-> $past(pwm_cycle_start_i) || $past(avs_write_i))
    else $error("release without cause");
  a_irq_sticky: assert property ($fell(irq_o) |-> $past(avs_write_i))
    else $error("irq dropped alone");
  c_set: cover property ($rose(act));
  c_drop: cover property ($fell(act));
  c_irq: cover property ($rose(irq_o));
endmodule : pfo_fault_override_checker

bind pfo_fault_override pfo_fault_override_checker chk (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .pwm_high_i(pwm_high_i),
  .pwm_low_i(pwm_low_i), .pwm_cycle_start_i(pwm_cycle_start_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .pwm_high_output_o(pwm_high_output_o), .pwm_low_output_o(pwm_low_output_o),
  .fault_override_active_o(fault_override_active_o), .irq_o(irq_o));

// ==== dv/tb_top.sv ====
// Self-checking bench for the PWM fault override block
`timescale 1ns/1ps
module tb_top;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ten = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] fset = 32'h0;
  logic [31:0] flt, rdat, q;
  logic hi, lo, cs, wt, ohi, olo, act, irq;
  int err_count = 0;
  int tests_run = 0;
  always #2.5 core_clk_i = ~core_clk_i;
  pfo_partner prt (.core_clk_i(core_clk_i), .run_i(ten), .fault_set_i(fset),
    .fault_o(flt), .pwm_high_o(hi), .pwm_low_o(lo), .cycle_start_o(cs));
  pfo_fault_override dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .fault_i(flt), .pwm_high_i(hi), .pwm_low_i(lo), .pwm_cycle_start_i(cs),
    .pwm_timebase_enable_i(ten), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .pwm_high_output_o(ohi),
    .pwm_low_output_o(olo), .fault_override_active_o(act), .irq_o(irq));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin @(posedge core_clk_i); n++; end while (wt !== 1'b0 && n < 20);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) begin err_count++; tally_and_finish(); end
  endtask : bus
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc
  task automatic waitv(ref logic s, input logic e);
    for (int n = 0; n < 40 && s !== e; n++) @(posedge core_clk_i);
    chk(s, e);
    if (s !== e) tally_and_finish();
  endtask : waitv
  // Negative case: long enough for the synchroniser and override stages
  task automatic settle(input logic e);
    repeat (8) @(posedge core_clk_i);
    chk(act, e);
  endtask : settle
  // One source code: unselected inputs active first, then the chosen one
  task automatic src_case(input logic [4:0] s);
    fset <= 32'h0;
    bus(1'b1, 4'h0, {24'h0, s, 3'h1});
    fset <= (s == 5'h1E) ? 32'hFFFFFFFF : ~(32'h1 << s);
    settle(1'b0);
    fset <= 32'h1 << s;
    if (s != 5'h1E) begin
      waitv(act, 1'b1);
      fset <= 32'h0;
      waitv(act, 1'b0);
    end else begin
      settle(1'b0);
    end
  endtask : src_case
  initial begin
    repeat (20) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rdc(4'h0, 32'h00F8);
    bus(1'b1, 4'h2, 32'hFFFF);
    rdc(4'h2, 32'h0);
    rdc(4'h0, 32'h00F8);
    bus(1'b1, 4'hC, 32'h1);
    rdc(4'hC, 32'h1);
    bus(1'b1, 4'h8, 32'h0);
    bus(1'b1, 4'h0, 32'h7);
    fset <= 32'hFFFFFFFF;
    bus(1'b1, 4'h0, 32'h5);
    settle(1'b0);
    fset <= 32'hFFFFFFFE;
    waitv(act, 1'b1);
    @(posedge core_clk_i);
    chk({ohi, olo}, 2'h2);
    fset <= 32'h0;
    bus(1'b1, 4'h0, 32'h1);
    settle(1'b1);
    ten <= 1'b1;
    waitv(act, 1'b0);
    src_case(5'h00);
    src_case(5'h03);
    src_case(5'h1F);
    src_case(5'h1E);
    fset <= 32'h1;
    for (int m = 2; m < 4; m++) begin
      bus(1'b1, 4'h0, m);
      settle(1'b0);
    end
    bus(1'b1, 4'h4, 32'h3);
    bus(1'b1, 4'h0, 32'h0);
    waitv(act, 1'b1);
    rdc(4'h4, 32'h101);
    bus(1'b1, 4'h4, 32'h100);
    settle(1'b1);
    fset <= 32'h0;
    settle(1'b1);
    chk(irq, 1'b0);
    bus(1'b1, 4'h8, 32'h3);
    rdc(4'h8, 32'h3);
    waitv(irq, 1'b1);
    bus(1'b1, 4'h4, 32'h103);
    waitv(act, 1'b0);
    rdc(4'h4, 32'h2);
    bus(1'b1, 4'h4, 32'h3);
    waitv(irq, 1'b0);
    rdc(4'h4, 32'h0);
    tally_and_finish();
  end
endmodule : tb_top
